// ### frontend_tuning_gain_regs.sv
// Register bank for LO filter tuning, IF gain, IF filter corners and thermometer.
// Assumes a host on the three-wire serial port and a thermometer code from the sensor.
//
// Function
// [R1] Five-bit doubler filter code, read/write, reset zero.
// [R2] Four-bit quadrupler filter code, low nibble, reset zero.
// [R3] Seven-bit forward gain code in dB, 6 dB steps.
// [R4] Independent seven-bit reverse gain code, 6 dB steps.
// [R5] Upper nibble sets narrowband IF filter corner.
// [R6] Lower nibble sets wideband IF filter corner.
// [R7] Read-only five-bit temperature code; writes ignored.
// [R8] Temperature code steps 7.4 C, first at -44.6 C.
// [R9] Reserved bits read zero, writes ignored.
// [R10] Reads return last write; outputs update on write.
module frontend_tuning_gain_regs
    import frontend_tuning_pkg::*;
(
    // Clock and reset.
    input  wire logic                core_clk,
    input  wire logic                resetn,
    // Serial host pins.
    input  wire logic                csb_n,
    input  wire logic                sclk,
    input  wire logic                sdio_in,
    output logic                     sdio_out,
    output logic                     sdio_oe,
    // Thermometer code from the sensor.
    input  wire logic [TEMP_W-1:0]   temp_sensor_code,
    // Analog control codes.
    output logic [DOUBLER_W-1:0]     doubler_filter_code,
    output logic [QUAD_W-1:0]        quadrupler_filter_code,
    output logic [GAIN_W-1:0]        forward_gain_code,
    output logic [GAIN_W-1:0]        reverse_gain_code,
    output logic [CORNER_W-1:0]      narrowband_corner_code,
    output logic [CORNER_W-1:0]      wideband_corner_code,
    output logic [TEMP_W-1:0]        temperature_code
);

    reg_req_s               req;
    logic [DATA_W-1:0]      rd_data_ff;
    logic [TEMP_W-1:0]      temp_meta_ff;
    logic [TEMP_W-1:0]      temp_sync_ff;
    logic [TEMP_W-1:0]      temp_prev_ff;

    // Refuse field layouts that the read mux and the write decode cannot serve.
    if (DOUBLER_W > DATA_W || QUAD_W > DATA_W || TEMP_W > DATA_W) begin : g_field_fit
        $error("A tune or thermometer field is wider than a data byte.");
    end
    if (GAIN_W >= DATA_W) begin : g_gain_fit
        $error("A gain code leaves no reserved top bit.");
    end
    if (NARROW_LSB != WIDE_LSB + CORNER_W || NARROW_LSB + CORNER_W != DATA_W) begin : g_corner_fit
        $error("The corner fields do not fill the shared register.");
    end

    // Gain codes are whole dB in 6 dB steps; sensor scale in milli-degrees.
    if (GAIN_STEP_DB <= 0 || TEMP_STEP_MILLI_C <= 0 || TEMP_FIRST_MILLI_C >= 0) begin : g_scale
        $error("The gain step or thermometer scale is out of range.");
    end

    // Readback of one address; unmapped and reserved bits read zero.
    function automatic logic [DATA_W-1:0] read_mux(input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] v;
        v = BYTE_ZERO;
        case (a)
            ADDR_DOUBLER:  v = DATA_W'(doubler_filter_code);                 // [R9]
            ADDR_QUAD:     v = DATA_W'(quadrupler_filter_code);              // [R9]
            ADDR_FWD_GAIN: v = DATA_W'(forward_gain_code);                   // [R9]
            ADDR_REV_GAIN: v = DATA_W'(reverse_gain_code);                   // [R9]
            ADDR_IF_FILT:  v = {narrowband_corner_code, wideband_corner_code};
            ADDR_TEMP:     v = DATA_W'(temperature_code);                    // [R9]
            default:       v = BYTE_ZERO;
        endcase
        return v;
    endfunction : read_mux

    // Write strobe for one register address, shared by every field except the read-only temperature code.
    function automatic logic write_hit(input reg_req_s r, input logic [ADDR_W-1:0] a);
        return r.wr && (r.addr == a);
    endfunction : write_hit

    serial_target u_serial (
        .core_clk (core_clk),
        .resetn   (resetn),
        .csb_n    (csb_n),
        .sclk     (sclk),
        .sdio_in  (sdio_in),
        .sdio_out (sdio_out),
        .sdio_oe  (sdio_oe),
        .req      (req),
        .rd_data  (rd_data_ff)
    );

    // Read data is captured when the address phase completes.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data_ff <= BYTE_ZERO;
        end else if (req.rd) begin
            rd_data_ff <= read_mux(req.addr);                                // [R10]
        end
    end

    // LO doubler filter tune field.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            doubler_filter_code <= DOUBLER_RST;                              // [R1]
        end else if (write_hit(req, ADDR_DOUBLER)) begin
            doubler_filter_code <= req.data[DOUBLER_W-1:0];                  // [R1] [R9] [R10]
        end
    end

    // LO quadrupler filter tune field.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            quadrupler_filter_code <= QUAD_RST;                              // [R2]
        end else if (write_hit(req, ADDR_QUAD)) begin
            quadrupler_filter_code <= req.data[QUAD_W-1:0];                  // [R2] [R9] [R10]
        end
    end

    // Forward IF amplifier gain code.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            forward_gain_code <= GAIN_RST;
        end else if (write_hit(req, ADDR_FWD_GAIN)) begin
            forward_gain_code <= req.data[GAIN_W-1:0];                       // [R3] [R9] [R10]
        end
    end

    // Reverse IF amplifier gain code, independent of the forward one.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            reverse_gain_code <= GAIN_RST;
        end else if (write_hit(req, ADDR_REV_GAIN)) begin
            reverse_gain_code <= req.data[GAIN_W-1:0];                       // [R4] [R9] [R10]
        end
    end

    // Narrowband IF filter corner, upper nibble of the shared register.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            narrowband_corner_code <= CORNER_RST;
        end else if (write_hit(req, ADDR_IF_FILT)) begin
            narrowband_corner_code <= req.data[NARROW_LSB +: CORNER_W];      // [R5] [R10]
        end
    end

    // Wideband IF filter corner, lower nibble of the shared register.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wideband_corner_code <= CORNER_RST;
        end else if (write_hit(req, ADDR_IF_FILT)) begin
            wideband_corner_code <= req.data[WIDE_LSB +: CORNER_W];          // [R6] [R10]
        end
    end

    // Sensor code passes two flip-flops; a third stage shows whether it has settled.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            temp_meta_ff <= TEMP_RST;
            temp_sync_ff <= TEMP_RST;
            temp_prev_ff <= TEMP_RST;
        end else begin
            temp_meta_ff <= temp_sensor_code;
            temp_sync_ff <= temp_meta_ff;
            temp_prev_ff <= temp_sync_ff;
        end
    end

    // Only a settled code is taken, so a multi-bit change never tears; host writes never reach it.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            temperature_code <= TEMP_RST;
        end else if (temp_prev_ff == temp_sync_ff) begin
            temperature_code <= temp_sync_ff;                                // [R7] [R8]
        end
    end

endmodule : frontend_tuning_gain_regs

// ### frontend_tuning_pkg.sv
// Constants and carrier types shared by the front-end tuning register bank.
// Assumes a single core clock domain and a three-wire serial host port.
package frontend_tuning_pkg;

    // Serial frame layout: one direction bit, address bits, then one data byte.
    localparam int unsigned ADDR_W      = 15;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned CMD_BITS    = 16;
    localparam int unsigned FRAME_BITS  = 24;
    localparam int unsigned CNT_W       = 5;

    // Register addresses.
    localparam logic [14:0] ADDR_DOUBLER   = 15'h0021;
    localparam logic [14:0] ADDR_QUAD      = 15'h0022;
    localparam logic [14:0] ADDR_FWD_GAIN  = 15'h0023;
    localparam logic [14:0] ADDR_REV_GAIN  = 15'h0024;
    localparam logic [14:0] ADDR_IF_FILT   = 15'h0025;
    localparam logic [14:0] ADDR_TEMP      = 15'h0026;

    // Field widths and positions.
    localparam int unsigned DOUBLER_W   = 5;
    localparam int unsigned QUAD_W      = 4;
    localparam int unsigned GAIN_W      = 7;
    localparam int unsigned CORNER_W    = 4;
    localparam int unsigned NARROW_LSB  = 4;
    localparam int unsigned WIDE_LSB    = 0;
    localparam int unsigned TEMP_W      = 5;

    // Reset values.
    localparam logic [4:0] DOUBLER_RST  = 5'h00;
    localparam logic [3:0] QUAD_RST     = 4'h0;
    localparam logic [6:0] GAIN_RST     = 7'h00;
    localparam logic [3:0] CORNER_RST   = 4'h0;
    localparam logic [4:0] TEMP_RST     = 5'h00;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;

    // Gain code step and thermometer scale, in their own units.
    localparam int GAIN_STEP_DB        = 6;
    localparam int TEMP_STEP_MILLI_C   = 7400;
    localparam int TEMP_FIRST_MILLI_C  = -44600;

    // Serial engine states.
    typedef enum logic [3:0] {
        ST_CMD  = 4'b0001,
        ST_WR   = 4'b0010,
        ST_RD   = 4'b0100,
        ST_DONE = 4'b1000
    } spi_state_e;

    // Register access request from the serial engine.
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [14:0]       addr;
        logic [7:0]        data;
    } reg_req_s;

endpackage : frontend_tuning_pkg

// ### ftg_props.sv
// Checker for the tuning register bank, watching only its ports.
// Assumes a host in serial mode 0 sending 24-clock frames.
module ftg_props
    import frontend_tuning_pkg::*;
(
    // Clock, reset and serial pins.
    input wire logic                 core_clk,
    input wire logic                 resetn,
    input wire logic                 csb_n,
    input wire logic                 sclk,
    input wire logic                 sdio_in,
    input wire logic                 sdio_out,
    input wire logic                 sdio_oe,
    // Sensor and control codes.
    input wire logic [TEMP_W-1:0]    temp_sensor_code,
    input wire logic [DOUBLER_W-1:0] doubler_filter_code,
    input wire logic [QUAD_W-1:0]    quadrupler_filter_code,
    input wire logic [GAIN_W-1:0]    forward_gain_code,
    input wire logic [GAIN_W-1:0]    reverse_gain_code,
    input wire logic [CORNER_W-1:0]  narrowband_corner_code,
    input wire logic [CORNER_W-1:0]  wideband_corner_code,
    input wire logic [TEMP_W-1:0]    temperature_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sclk_q_ff;
    logic [4:0]  cnt_ff;
    logic [15:0] sh_ff;
    logic [30:0] ctl;
    assign ctl = {doubler_filter_code, quadrupler_filter_code, forward_gain_code,
                  reverse_gain_code, narrowband_corner_code, wideband_corner_code};
    // Counts serial rises in a frame and keeps the command bits.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sclk_q_ff <= 1'b0;
            cnt_ff    <= 5'h00;
            sh_ff     <= 16'h0000;
        end else begin
            sclk_q_ff <= sclk;
            cnt_ff    <= csb_n ? 5'h00 : cnt_ff + {4'h0, sclk & ~sclk_q_ff};
            if (sclk && !sclk_q_ff && cnt_ff < 5'h10) begin
                sh_ff <= {sh_ff[14:0], sdio_in};
            end
        end
    end
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!resetn);
    temp_track_a: assert property ($stable(temp_sensor_code) [*8] |-> temperature_code == temp_sensor_code)
        else $error("temperature code does not follow sensor");
    temp_ro_a: assert property ($stable(temp_sensor_code) [*8] |=> $stable(temperature_code))
        else $error("temperature code moved without sensor change");
    ctrl_hold_a: assert property (csb_n [*8] |-> $stable(ctl))
        else $error("control code changed while idle");
    frame_len_a: assert property (!$stable(ctl) |-> !csb_n && cnt_ff == 5'h18)
        else $error("control code changed outside a full frame");
    read_start_a: assert property ($rose(sdio_oe) |-> !csb_n && cnt_ff == 5'h10)
        else $error("read data driven at wrong bit");
    rsvd_zero_a: assert property (sdio_oe && cnt_ff == 5'h10 && sh_ff[14:0] != ADDR_IF_FILT |-> !sdio_out)
        else $error("reserved top bit read as one");
    oe_end_a: assert property (cnt_ff == 5'h18 && $fell(sclk) |-> ##[1:5] !sdio_oe)
        else $error("data pin still driven after frame");
    gain_indep_a: assert property (!$stable(forward_gain_code) |-> $stable(reverse_gain_code))
        else $error("gain codes not independent");
    cover property ($rose(sdio_oe));
    cover property (!$stable(forward_gain_code));
    cover property (!$stable(temperature_code));
    cover property ($rose(csb_n) && cnt_ff != 5'h18);
endmodule : ftg_props

bind frontend_tuning_gain_regs ftg_props u_props (.core_clk, .resetn, .csb_n, .sclk, .sdio_in,
    .sdio_out, .sdio_oe, .temp_sensor_code, .doubler_filter_code, .quadrupler_filter_code,
    .forward_gain_code, .reverse_gain_code, .narrowband_corner_code, .wideband_corner_code,
    .temperature_code);

// ### serial_host.sv
// Host model that runs three-wire serial frames towards the register bank.
// Assumes mode 0 and a serial clock of ten core cycles per bit.
module serial_host
    import frontend_tuning_pkg::*;
(
    // Clock.
    input  wire logic core_clk,
    // Serial pins.
    output logic      csb_n,
    output logic      sclk,
    output logic      sdio_in,
    input  wire logic sdio_out,
    input  wire logic sdio_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic host_sd;
    assign sdio_in = sdio_oe ? sdio_out : host_sd;
    initial begin
        csb_n   = 1'b1;
        sclk    = 1'b0;
        host_sd = 1'b0;
    end
    task automatic ticks(input int n);
        repeat (n) @(posedge core_clk);
    endtask : ticks
    // Runs nbits of a frame; a released line toggles every bit.
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] d,
                        input int nbits, output logic [7:0] q);
        logic [23:0] f;
        f = {rd, a, d};
        q = 8'h00;
        csb_n <= 1'b0;
        for (int i = 23; i > 23 - nbits; i--) begin
            host_sd <= (rd && i < 8) ? ~host_sd : f[i];
            ticks(5);
            sclk <= 1'b1;
            if (i < 8) q[i] = sdio_in;
            ticks(5);
            sclk <= 1'b0;
        end
        host_sd <= ~host_sd;
        ticks(5);
        csb_n <= 1'b1;
        ticks(6);
    endtask : xfer
endmodule : serial_host

// ### serial_target.sv
// Three-wire serial target that turns host frames into register requests.
// Assumes the serial clock runs well below a quarter of the core clock.
module serial_target
    import frontend_tuning_pkg::*;
(
    // Clock and reset.
    input  wire logic       core_clk,
    input  wire logic       resetn,
    // Serial pins.
    input  wire logic       csb_n,
    input  wire logic       sclk,
    input  wire logic       sdio_in,
    output logic            sdio_out,
    output logic            sdio_oe,
    // Register side.
    output reg_req_s        req,
    input  wire logic [7:0] rd_data
);

    logic             csb_meta_ff, csb_sync_ff;
    logic             sclk_meta_ff, sclk_sync_ff, sclk_prev_ff;
    logic             sdio_meta_ff, sdio_sync_ff;
    logic             rise, fall;
    spi_state_e       state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [22:0]      shift_ff;
    logic [6:0]       out_sr_ff;

    // Pins pass two flip-flops before any logic reads them.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            csb_meta_ff  <= 1'b1;
            csb_sync_ff  <= 1'b1;
            sclk_meta_ff <= 1'b0;
            sclk_sync_ff <= 1'b0;
            sclk_prev_ff <= 1'b0;
            sdio_meta_ff <= 1'b0;
            sdio_sync_ff <= 1'b0;
        end else begin
            csb_meta_ff  <= csb_n;
            csb_sync_ff  <= csb_meta_ff;
            sclk_meta_ff <= sclk;
            sclk_sync_ff <= sclk_meta_ff;
            sclk_prev_ff <= sclk_sync_ff;
            sdio_meta_ff <= sdio_in;
            sdio_sync_ff <= sdio_meta_ff;
        end
    end

    assign rise = sclk_sync_ff & ~sclk_prev_ff & ~csb_sync_ff;
    assign fall = ~sclk_sync_ff & sclk_prev_ff & ~csb_sync_ff;

    // Frame sequencer: address phase, then write capture or read shift-out.
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_ff  <= ST_CMD;
            cnt_ff    <= '0;
            shift_ff  <= '0;
            out_sr_ff <= '0;
            sdio_out  <= 1'b0;
            sdio_oe   <= 1'b0;
            req       <= '0;
        end else begin
            req.wr <= 1'b0;
            req.rd <= 1'b0;
            if (csb_sync_ff) begin
                state_ff <= ST_CMD;
                cnt_ff   <= '0;
                sdio_oe  <= 1'b0;
            end else if (rise) begin
                shift_ff <= {shift_ff[21:0], sdio_sync_ff};
                cnt_ff   <= cnt_ff + CNT_W'(1);
                case (state_ff)
                    ST_CMD: begin
                        if (cnt_ff == CNT_W'(CMD_BITS - 1)) begin
                            req.addr <= {shift_ff[13:0], sdio_sync_ff};
                            if (shift_ff[14]) begin
                                req.rd   <= 1'b1;
                                state_ff <= ST_RD;
                            end else begin
                                state_ff <= ST_WR;
                            end
                        end
                    end
                    ST_WR: begin
                        if (cnt_ff == CNT_W'(FRAME_BITS - 1)) begin
                            req.wr   <= 1'b1;
                            req.data <= {shift_ff[6:0], sdio_sync_ff};
                            state_ff <= ST_DONE;
                        end
                    end
                    ST_RD, ST_DONE: begin
                    end
                    default: begin
                        state_ff <= ST_DONE;
                    end
                endcase
            end else if (fall && state_ff == ST_RD) begin
                if (cnt_ff == CNT_W'(CMD_BITS)) begin
                    sdio_out  <= rd_data[7];
                    out_sr_ff <= rd_data[6:0];
                    sdio_oe   <= 1'b1;
                end else if (cnt_ff == CNT_W'(FRAME_BITS)) begin
                    sdio_oe  <= 1'b0;
                    state_ff <= ST_DONE;
                end else begin
                    sdio_out  <= out_sr_ff[6];
                    out_sr_ff <= {out_sr_ff[5:0], 1'b0};
                end
            end
        end
    end

endmodule : serial_target

// ### tb.sv
// Self-checking bench for the tuning register bank driven by a serial host model.
// Assumes the checker is bound to the bank and a 50 MHz core clock.
module tb
    import frontend_tuning_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [14:0] a; logic [7:0] d, r; logic [30:0] o;} row_s;
    logic        core_clk, resetn, csb_n, sclk, sdio_in, sdio_out, sdio_oe;
    logic [4:0]  temp_sensor_code, doubler_filter_code, temperature_code;
    logic [3:0]  quadrupler_filter_code, narrowband_corner_code, wideband_corner_code;
    logic [6:0]  forward_gain_code, reverse_gain_code;
    logic [7:0]  q;
    logic [30:0] outs;
    int          miscompares, samples_checked;
    row_s        rows [8] = '{'{15'h21, 8'hff, 8'h1f, 31'h7c000000},
        '{15'h22, 8'hff, 8'h0f, 31'h7fc00000}, '{15'h23, 8'h8c, 8'h0c, 31'h7fc60000},
        '{15'h24, 8'h7e, 8'h7e, 31'h7fc67e00}, '{15'h25, 8'ha5, 8'ha5, 31'h7fc67ea5},
        '{15'h26, 8'hff, 8'h13, 31'h7fc67ea5}, '{15'h27, 8'h55, 8'h00, 31'h7fc67ea5},
        '{15'h21, 8'h0a, 8'h0a, 31'h2bc67ea5}};
    assign outs = {doubler_filter_code, quadrupler_filter_code, forward_gain_code,
                   reverse_gain_code, narrowband_corner_code, wideband_corner_code};
    frontend_tuning_gain_regs dut (.core_clk, .resetn, .csb_n, .sclk, .sdio_in, .sdio_out,
        .sdio_oe, .temp_sensor_code, .doubler_filter_code, .quadrupler_filter_code,
        .forward_gain_code, .reverse_gain_code, .narrowband_corner_code,
        .wideband_corner_code, .temperature_code);
    serial_host host (.core_clk, .csb_n, .sclk, .sdio_in, .sdio_out, .sdio_oe);
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask : chk_byte
    task automatic chk_outs(input logic [30:0] got, input logic [30:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: codes %h, want %h", $time, got, exp);
        end
    endtask : chk_outs
    task automatic conclude();
        $display("checked %0d, mismatched %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        #400000;
        miscompares++;
        conclude();
    end
    initial begin
        resetn = 1'b0;
        temp_sensor_code = 5'h13;
        miscompares = 0;
        samples_checked = 0;
        host.ticks(4);
        resetn <= 1'b1;
        host.ticks(4);
        foreach (rows[i]) begin
            host.xfer(1'b0, rows[i].a, rows[i].d, 24, q);
            chk_outs(outs, rows[i].o);
            host.xfer(1'b1, rows[i].a, 8'h00, 24, q);
            chk_byte(q, rows[i].r);
            $display("row %0d done", i);
        end
        host.xfer(1'b0, ADDR_IF_FILT, 8'h3c, 20, q);
        chk_outs(outs, 31'h2bc67ea5);
        $display("short frame done");
        temp_sensor_code <= 5'h1f;
        host.xfer(1'b0, ADDR_TEMP, 8'h00, 24, q);
        host.xfer(1'b1, ADDR_TEMP, 8'h00, 24, q);
        chk_byte(q, 8'h1f);
        chk_byte({3'h0, temperature_code}, 8'h1f);
        $display("thermometer done");
        resetn <= 1'b0;
        host.ticks(4);
        chk_outs(outs, 31'h0);
        resetn <= 1'b1;
        host.ticks(4);
        for (int a = 32'h21; a < 32'h26; a++) begin
            host.xfer(1'b1, 15'(a), 8'h00, 24, q);
            chk_byte(q, 8'h00);
        end
        $display("reset done");
        conclude();
    end
endmodule : tb
